// ===== acor_pkg.sv
package acor_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ACC_W   = 32;
   localparam int WORD_W  = 16;
   localparam int ADDR_W  = 16;
   localparam int CNT_W   = 6;
   localparam int MSB_POS = 31;

   // ----------------------------------------------------------------
   // Counts and reset values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0]  CNT_MIN   = 6'h01;
   localparam logic [CNT_W-1:0]  CNT_MAX   = 6'h20;
   localparam logic [ACC_W-1:0]  ACC_RST   = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
   localparam logic [ADDR_W-1:0] HI_OFFSET = 16'h0001;

   // ----------------------------------------------------------------
   // Operations and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      or_word_op,
      or_double_op,
      or_formatted_op
   } acor_op_e;

   typedef enum logic [2:0] {
      st_idle,
      st_ptr,
      st_lo,
      st_hi,
      st_bit,
      st_fin
   } acor_state_e;

endpackage : acor_pkg

// ===== acor_res_if.sv
`timescale 1ns/10ps
interface acor_res_if;
   logic                    upd;
   logic                    upd_neg;
   logic [acor_pkg::ACC_W-1:0] result;

   modport src (output upd, output upd_neg, output result);
   modport snk (input upd, input upd_neg, input result);
endinterface : acor_res_if

// ===== acor_flags.sv
`timescale 1ns/10ps
module acor_flags (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Result from the datapath
   acor_res_if.snk   res,
   // Status
   output logic      zero_result_flag,
   output logic      negative_result_flag,
   output logic      op_done
);

   logic zero_ff;
   logic neg_ff;
   logic done_ff;
   wire  nxt_zero = (res.result == acor_pkg::ACC_RST);
   wire  nxt_neg  = res.result[acor_pkg::MSB_POS];

   // Flags move only on an update; otherwise they hold until the next one
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         zero_ff <= 1'b0;
         neg_ff  <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= res.upd;
         if (res.upd) begin
            zero_ff <= nxt_zero;
         end
         if (res.upd && res.upd_neg) begin
            neg_ff <= nxt_neg;
         end
      end
   end

   assign zero_result_flag     = zero_ff;
   assign negative_result_flag = neg_ff;
   assign op_done              = done_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_zero_clears: assert property (@(posedge mclk) disable iff (sys_rst)
      res.upd && (res.result != acor_pkg::ACC_RST) |=> !zero_result_flag)
      else $error("zero flag stale after nonzero result");

   a_flags_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      !res.upd |=> $stable(zero_result_flag) && $stable(negative_result_flag))
      else $error("flag moved without an update");

endmodule : acor_flags

// ===== acor_unit.sv
`timescale 1ns/10ps
// Behaviour
// - Word op ORs memory word into low half
// - Word op sets zero flag on zero
// - Double op ORs two words or constant
// - Double op updates zero and negative flags
// - Formatted op ORs 0..32 consecutive bits
// - Formatted op updates zero and negative flags
// - Flags hold until next op that updates them
module acor_unit (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           sys_rst,
   // Command from the sequencer
   input  wire logic                           cmd_valid,
   input  wire acor_pkg::acor_op_e             cmd_op,
   input  wire logic                           cmd_indirect,
   input  wire logic                           cmd_use_const,
   input  wire logic [acor_pkg::ADDR_W-1:0]    cmd_addr,
   input  wire logic [acor_pkg::ACC_W-1:0]     cmd_const,
   input  wire logic [acor_pkg::CNT_W-1:0]     cmd_count,
   output logic                                cmd_ready,
   // Accumulator load
   input  wire logic                           acc_load,
   input  wire logic [acor_pkg::ACC_W-1:0]     acc_load_data,
   // Word memory
   output logic                                mem_rd_en,
   output logic [acor_pkg::ADDR_W-1:0]         mem_addr,
   input  wire logic                           mem_rd_valid,
   input  wire logic [acor_pkg::WORD_W-1:0]    mem_rd_data,
   // Bit memory
   output logic                                bit_rd_en,
   output logic [acor_pkg::ADDR_W-1:0]         bit_addr,
   input  wire logic                           bit_rd_valid,
   input  wire logic                           bit_rd_data,
   // Results
   output logic [acor_pkg::ACC_W-1:0]          acc,
   output logic                                zero_result_flag,
   output logic                                negative_result_flag,
   output logic                                op_done
);

   acor_pkg::acor_state_e              st_ff, nxt_st;
   acor_pkg::acor_op_e                 op_ff, nxt_op;
   logic [acor_pkg::ACC_W-1:0]         acc_ff, nxt_acc;
   logic [acor_pkg::ADDR_W-1:0]        maddr_ff, nxt_maddr;
   logic [acor_pkg::ADDR_W-1:0]        baddr_ff, nxt_baddr;
   logic [acor_pkg::CNT_W-1:0]         cnt_ff, nxt_cnt;
   logic [acor_pkg::CNT_W-1:0]         idx_ff, nxt_idx;
   logic                               mrd_ff, brd_ff, rdy_ff;

   acor_res_if res ();

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Counts above the maximum are clamped rather than refused
   wire [acor_pkg::CNT_W-1:0]  cnt_clamp = (cmd_count > acor_pkg::CNT_MAX) ? acor_pkg::CNT_MAX : cmd_count;
   // Gated by cmd_ready so nothing is taken in the first cycle after reset
   wire                        take      = (st_ff == acor_pkg::st_idle) && cmd_valid && rdy_ff;
   wire [acor_pkg::CNT_W-1:0]  idx_inc   = idx_ff + acor_pkg::CNT_MIN;
   wire                        last_bit  = (idx_inc >= cnt_ff);
   wire [acor_pkg::ACC_W-1:0]  bit_mask  = {{(acor_pkg::ACC_W-1){1'b0}}, bit_rd_data} << idx_ff[4:0];
   wire [acor_pkg::WORD_W-1:0] lo_or     = acc_ff[acor_pkg::WORD_W-1:0] | mem_rd_data;
   wire [acor_pkg::WORD_W-1:0] hi_or     = acc_ff[acor_pkg::ACC_W-1:acor_pkg::WORD_W] | mem_rd_data;
   wire                        is_rd     = (nxt_st == acor_pkg::st_ptr) || (nxt_st == acor_pkg::st_lo) ||
                                           (nxt_st == acor_pkg::st_hi);
   wire                        nxt_mrd   = is_rd && (nxt_st != st_ff);
   wire                        nxt_brd   = (nxt_st == acor_pkg::st_bit) &&
                                           ((st_ff != acor_pkg::st_bit) || bit_rd_valid);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st    = st_ff;
      nxt_op    = op_ff;
      nxt_acc   = acc_ff;
      nxt_maddr = maddr_ff;
      nxt_baddr = baddr_ff;
      nxt_cnt   = cnt_ff;
      nxt_idx   = idx_ff;
      unique case (st_ff)
         acor_pkg::st_idle: begin
            if (take) begin
               nxt_op    = cmd_op;
               nxt_maddr = cmd_addr;
               nxt_baddr = cmd_addr;
               nxt_cnt   = cnt_clamp;
               nxt_idx   = '0;
               if (cmd_op == acor_pkg::or_formatted_op) begin
                  nxt_st = (cnt_clamp == '0) ? acor_pkg::st_fin : acor_pkg::st_bit;
               end else if (cmd_op == acor_pkg::or_double_op && cmd_use_const) begin
                  nxt_acc = acc_ff | cmd_const;
                  nxt_st  = acor_pkg::st_fin;
               end else begin
                  nxt_st = cmd_indirect ? acor_pkg::st_ptr : acor_pkg::st_lo;
               end
            end else if (acc_load && rdy_ff) begin
               nxt_acc = acc_load_data;
            end
         end
         acor_pkg::st_ptr: begin
            if (mem_rd_valid) begin
               nxt_maddr = mem_rd_data;
               nxt_st    = acor_pkg::st_lo;
            end
         end
         acor_pkg::st_lo: begin
            if (mem_rd_valid) begin
               nxt_acc[acor_pkg::WORD_W-1:0] = lo_or;
               if (op_ff == acor_pkg::or_double_op) begin
                  nxt_maddr = maddr_ff + acor_pkg::HI_OFFSET;
                  nxt_st    = acor_pkg::st_hi;
               end else begin
                  nxt_st = acor_pkg::st_fin;
               end
            end
         end
         acor_pkg::st_hi: begin
            if (mem_rd_valid) begin
               nxt_acc[acor_pkg::ACC_W-1:acor_pkg::WORD_W] = hi_or;
               nxt_st = acor_pkg::st_fin;
            end
         end
         acor_pkg::st_bit: begin
            if (bit_rd_valid) begin
               nxt_acc   = acc_ff | bit_mask;
               nxt_idx   = idx_inc;
               nxt_baddr = baddr_ff + acor_pkg::HI_OFFSET;
               if (last_bit) begin
                  nxt_st = acor_pkg::st_fin;
               end
            end
         end
         acor_pkg::st_fin: begin
            nxt_st = acor_pkg::st_idle;
         end
         default: begin
            nxt_st = acor_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff    <= acor_pkg::st_idle;
         op_ff    <= acor_pkg::or_word_op;
         acc_ff   <= acor_pkg::ACC_RST;
         maddr_ff <= acor_pkg::ADDR_RST;
         baddr_ff <= acor_pkg::ADDR_RST;
         cnt_ff   <= '0;
         idx_ff   <= '0;
         mrd_ff   <= 1'b0;
         brd_ff   <= 1'b0;
         rdy_ff   <= 1'b0;
      end else begin
         st_ff    <= nxt_st;
         op_ff    <= nxt_op;
         acc_ff   <= nxt_acc;
         maddr_ff <= nxt_maddr;
         baddr_ff <= nxt_baddr;
         cnt_ff   <= nxt_cnt;
         idx_ff   <= nxt_idx;
         mrd_ff   <= nxt_mrd;
         brd_ff   <= nxt_brd;
         rdy_ff   <= (nxt_st == acor_pkg::st_idle);
      end
   end

   // ----------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------
   // Word op leaves the negative flag alone; the others update both
   assign res.upd     = (st_ff == acor_pkg::st_fin);
   assign res.upd_neg = (op_ff != acor_pkg::or_word_op);
   assign res.result  = acc_ff;

   acor_flags u_flags (
      .mclk                 (mclk),
      .sys_rst              (sys_rst),
      .res                  (res),
      .zero_result_flag     (zero_result_flag),
      .negative_result_flag (negative_result_flag),
      .op_done              (op_done)
   );

   assign cmd_ready = rdy_ff;
   assign mem_rd_en = mrd_ff;
   assign mem_addr  = maddr_ff;
   assign bit_rd_en = brd_ff;
   assign bit_addr  = baddr_ff;
   assign acc       = acc_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_word_data;
      st_ff == acor_pkg::st_lo && op_ff == acor_pkg::or_word_op && mem_rd_valid;
   endsequence

   sequence s_fin(acor_pkg::acor_op_e o);
      st_ff == acor_pkg::st_fin && op_ff == o;
   endsequence

   a_word_low_or: assert property (@(posedge mclk) disable iff (sys_rst)
      s_word_data |=> acc[15:0] == ($past(acc[15:0]) | $past(mem_rd_data)) && $stable(acc[31:16]))
      else $error("word op did not OR into low half only");

   a_word_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      s_fin(acor_pkg::or_word_op) |=> zero_result_flag == (acc == 32'h0000_0000) &&
                                       $stable(negative_result_flag) && op_done)
      else $error("word op zero flag wrong");

   a_double_const: assert property (@(posedge mclk) disable iff (sys_rst)
      take && cmd_op == acor_pkg::or_double_op && cmd_use_const
      |=> acc == ($past(acc) | $past(cmd_const)) ##1 op_done)
      else $error("double constant OR wrong");

   a_double_flags: assert property (@(posedge mclk) disable iff (sys_rst)
      s_fin(acor_pkg::or_double_op) |=> negative_result_flag == acc[31] &&
                                         zero_result_flag == (acc == 32'h0000_0000))
      else $error("double op flags wrong");

   a_fmt_flags: assert property (@(posedge mclk) disable iff (sys_rst)
      s_fin(acor_pkg::or_formatted_op) |=> negative_result_flag == acc[31] &&
                                            zero_result_flag == (acc == 32'h0000_0000))
      else $error("formatted op flags wrong");

   a_fmt_bit_map: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == acor_pkg::st_bit && bit_rd_valid
      |=> acc == ($past(acc) | ({31'h0000_0000, $past(bit_rd_data)} << $past(idx_ff[4:0]))))
      else $error("formatted bit landed in wrong place");

   a_fmt_bit_count: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == acor_pkg::st_bit |-> idx_ff < cnt_ff && cnt_ff <= 6'h20)
      else $error("formatted op read past its count");

   a_ptr_follow: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == acor_pkg::st_ptr && mem_rd_valid |=> mem_rd_en && mem_addr == $past(mem_rd_data))
      else $error("pointer not followed");

endmodule : acor_unit

// ===== acor_mem_model.sv
`timescale 1ns/10ps
module acor_mem_model (
   // Clock and answer delay
   input  wire logic        mclk,
   input  wire logic [1:0]  lat,
   // Word memory
   input  wire logic        mem_rd_en,
   input  wire logic [15:0] mem_addr,
   output logic             mem_rd_valid,
   output logic [15:0]      mem_rd_data,
   // Bit memory
   input  wire logic        bit_rd_en,
   input  wire logic [15:0] bit_addr,
   output logic             bit_rd_valid,
   output logic             bit_rd_data
);
   logic [15:0] wmem [0:255];
   logic        bmem [0:255];
   logic [7:0]  wa_ff, ba_ff;
   logic [1:0]  wc_ff, bc_ff;
   logic        wb_ff = 1'b0;
   logic        bb_ff = 1'b0;
   initial begin
      mem_rd_valid = 1'b0;
      mem_rd_data  = 16'h0;
      bit_rd_valid = 1'b0;
      bit_rd_data  = 1'b0;
   end
   // ----------------------------------------------------------------
   // Reads: answer lat+1 cycles after the pulse
   // ----------------------------------------------------------------
   // Data lines toggle when idle so a stale value is never mistaken for an answer
   always @(posedge mclk) begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd_en) begin
         wb_ff <= 1'b1;
         wc_ff <= lat;
         wa_ff <= mem_addr[7:0];
      end else if (wb_ff && wc_ff != 2'h0) begin
         wc_ff <= wc_ff - 2'h1;
      end else if (wb_ff) begin
         wb_ff        <= 1'b0;
         mem_rd_valid <= 1'b1;
         mem_rd_data  <= wmem[wa_ff];
      end
   end
   always @(posedge mclk) begin
      bit_rd_valid <= 1'b0;
      bit_rd_data  <= ~bit_rd_data;
      if (bit_rd_en) begin
         bb_ff <= 1'b1;
         bc_ff <= lat;
         ba_ff <= bit_addr[7:0];
      end else if (bb_ff && bc_ff != 2'h0) begin
         bc_ff <= bc_ff - 2'h1;
      end else if (bb_ff) begin
         bb_ff        <= 1'b0;
         bit_rd_valid <= 1'b1;
         bit_rd_data  <= bmem[ba_ff];
      end
   end
endmodule : acor_mem_model

// ===== accumulator_or_unit_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module accumulator_or_unit_tb;
   localparam acor_pkg::acor_op_e OPW = acor_pkg::or_word_op;
   localparam acor_pkg::acor_op_e OPD = acor_pkg::or_double_op;
   localparam acor_pkg::acor_op_e OPF = acor_pkg::or_formatted_op;
   logic               mclk = 1'b0;
   logic               sys_rst = 1'b1;
   logic               cmd_valid = 1'b0;
   acor_pkg::acor_op_e cmd_op = OPW;
   logic               cmd_indirect = 1'b0;
   logic               cmd_use_const = 1'b0;
   logic [15:0]        cmd_addr = 16'h0;
   logic [31:0]        cmd_const = 32'h0;
   logic [5:0]         cmd_count = 6'h0;
   logic               acc_load = 1'b0;
   logic [31:0]        acc_load_data = 32'h0;
   logic [1:0]         lat = 2'h0;
   logic               cmd_ready, mem_rd_en, mem_rd_valid, bit_rd_en, bit_rd_valid, bit_rd_data;
   logic               zero_result_flag, negative_result_flag, op_done;
   logic [15:0]        mem_addr, mem_rd_data, bit_addr;
   logic [31:0]        acc;
   int                 n_mismatch = 0;
   int                 check_count = 0;
   always #20 mclk = ~mclk;
   acor_unit dut (.mclk, .sys_rst, .cmd_valid, .cmd_op, .cmd_indirect, .cmd_use_const, .cmd_addr,
      .cmd_const, .cmd_count, .cmd_ready, .acc_load, .acc_load_data, .mem_rd_en, .mem_addr,
      .mem_rd_valid, .mem_rd_data, .bit_rd_en, .bit_addr, .bit_rd_valid, .bit_rd_data, .acc,
      .zero_result_flag, .negative_result_flag, .op_done);
   acor_mem_model mem (.mclk, .lat, .mem_rd_en, .mem_addr, .mem_rd_valid, .mem_rd_data,
      .bit_rd_en, .bit_addr, .bit_rd_valid, .bit_rd_data);
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   // Entered 1 ns after an edge; leaves at the op_done cycle so ops run back to back
   task automatic do_op(input acor_pkg::acor_op_e op, input logic ind, input logic uc,
                        input logic [15:0] ad, input logic [31:0] k, input logic [5:0] cnt,
                        input logic [31:0] ea, input logic ez, input logic en);
      int n;
      n             = 0;
      cmd_op        = op;
      cmd_indirect  = ind;
      cmd_use_const = uc;
      cmd_addr      = ad;
      cmd_const     = k;
      cmd_count     = cnt;
      cmd_valid     = 1'b1;
      // cmd_ready is registered: high here means the next edge takes the command
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge mclk);
         #1 n++;
      end
      @(posedge mclk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (op_done !== 1'b1 && n < 200) begin
         @(posedge mclk);
         #1 n++;
      end
      `CHK(op_done, 1'b1)
      `CHK(acc, ea)
      `CHK(zero_result_flag, ez)
      `CHK(negative_result_flag, en)
   endtask : do_op
   task automatic load_acc(input logic [31:0] v);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge mclk);
         #1 n++;
      end
      acc_load_data = v;
      acc_load      = 1'b1;
      @(posedge mclk);
      #1 acc_load = 1'b0;
   endtask : load_acc
   // Bits past the count are set so a count slip shows in acc
   task automatic set_bits(input logic [7:0] st, input logic [31:0] p, input int cnt);
      for (int i = 0; i < 36; i++) begin
         mem.bmem[st + i[7:0]] = (i < cnt) ? p[i] : 1'b1;
      end
   endtask : set_bits
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_word;
      lat = 2'h0;
      mem.wmem[8'h10] = 16'h0034;
      mem.wmem[8'h11] = 16'h0000;
      load_acc(32'h8000_1200);
      do_op(OPW, 1'b0, 1'b0, 16'h0010, 32'h0, 6'h0, 32'h8000_1234, 1'b0, 1'b0);
      load_acc(32'h0);
      do_op(OPW, 1'b0, 1'b0, 16'h0011, 32'h0, 6'h0, 32'h0, 1'b1, 1'b0);
      do_op(OPW, 1'b0, 1'b0, 16'h0010, 32'h0, 6'h0, 32'h34, 1'b0, 1'b0);
      $display("test word finished");
   endtask : t_word
   task automatic t_indirect;
      lat = 2'h3;
      mem.wmem[8'h20] = 16'h0030;
      mem.wmem[8'h30] = 16'h5a00;
      mem.wmem[8'h21] = 16'h0040;
      mem.wmem[8'h40] = 16'h0001;
      mem.wmem[8'h41] = 16'h8000;
      load_acc(32'h0000_00a5);
      do_op(OPW, 1'b1, 1'b0, 16'h0020, 32'h0, 6'h0, 32'h0000_5aa5, 1'b0, 1'b0);
      do_op(OPD, 1'b1, 1'b0, 16'h0021, 32'h0, 6'h0, 32'h8000_5aa5, 1'b0, 1'b1);
      $display("test indirect finished");
   endtask : t_indirect
   task automatic t_double;
      lat = 2'h1;
      mem.wmem[8'h50] = 16'h1111;
      mem.wmem[8'h51] = 16'h2222;
      load_acc(32'h0);
      do_op(OPD, 1'b0, 1'b1, 16'h0050, 32'h0, 6'h0, 32'h0, 1'b1, 1'b0);
      do_op(OPD, 1'b0, 1'b1, 16'h0050, 32'h8000_0000, 6'h0, 32'h8000_0000, 1'b0, 1'b1);
      do_op(OPD, 1'b0, 1'b0, 16'h0050, 32'hffff_ffff, 6'h0, 32'ha222_1111, 1'b0, 1'b1);
      $display("test double finished");
   endtask : t_double
   task automatic t_fmt;
      lat = 2'h0;
      set_bits(8'h80, 32'h1, 1);
      load_acc(32'h0);
      do_op(OPF, 1'b0, 1'b0, 16'h0080, 32'h0, 6'h01, 32'h1, 1'b0, 1'b0);
      lat = 2'h2;
      set_bits(8'h90, 32'ha, 4);
      load_acc(32'h0);
      do_op(OPF, 1'b0, 1'b0, 16'h0090, 32'h0, 6'h04, 32'ha, 1'b0, 1'b0);
      lat = 2'h0;
      set_bits(8'ha0, 32'h8000_0001, 32);
      load_acc(32'h0);
      do_op(OPF, 1'b0, 1'b0, 16'h00a0, 32'h0, 6'h20, 32'h8000_0001, 1'b0, 1'b1);
      set_bits(8'h80, 32'h0, 1);
      load_acc(32'h0);
      do_op(OPF, 1'b0, 1'b0, 16'h0080, 32'h0, 6'h01, 32'h0, 1'b1, 1'b0);
      $display("test formatted finished");
   endtask : t_fmt
   task automatic t_hold;
      repeat (5) @(posedge mclk);
      #1 load_acc(32'h8000_0000);
      `CHK(zero_result_flag, 1'b1)
      `CHK(negative_result_flag, 1'b0)
      $display("test hold finished");
   endtask : t_hold
   task automatic t_reset;
      sys_rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 `CHK(acc, 32'h0)
      `CHK({cmd_ready, zero_result_flag, negative_result_flag}, 3'h0)
      sys_rst = 1'b0;
      do_op(OPD, 1'b0, 1'b1, 16'h0, 32'h0000_0100, 6'h0, 32'h0000_0100, 1'b0, 1'b0);
      $display("test reset finished");
   endtask : t_reset
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk);
      #1 sys_rst = 1'b0;
      t_word;
      t_indirect;
      t_double;
      t_fmt;
      t_hold;
      t_reset;
      close_out;
   end
   initial begin
      #(40 * 5000);
      n_mismatch++;
      $display("watchdog expired at %0t", $time);
      close_out;
   end
endmodule : accumulator_or_unit_tb
